// [common/exst_defines.svh]
// Constants for the exception state status block: field positions, encodings and register offsets.
// Assumes inclusion by the package and the design module only.
`ifndef EXST_DEFINES_SVH
`define EXST_DEFINES_SVH
`define EXST_ADDR_STATUS 12'hD04
`define EXST_PEND_LSB 12
`define EXST_PEND_MSB 17
`define EXST_RETURN_TO_BASE_FLAG_BIT 11
`define EXST_ACT_MSB 5
`define EXST_VEC_NONE 6'h00
`define EXST_VEC_NMI 6'h02
`define EXST_VEC_FAULT_LAST 6'h06
`define EXST_VEC_SVCALL 6'h0B
`define EXST_VEC_PENDSVC 6'h0E
`define EXST_VEC_TICK 6'h0F
`define EXST_VEC_IRQ0 6'h10
`define EXST_VEC_IRQMAX 6'h3B
`define EXST_NUM_IRQ 44
`define EXST_NUM_SLOTS 64
`define EXST_PRIO_W 3
`define EXST_PRIO_NONE 4'h8
`define EXST_ZERO32 32'h0000_0000
`endif

// [common/exst_pkg.sv]
// Types shared by the exception state status block.
// Assumes the defines header is on the include path.
`include "exst_defines.svh"
package exst_pkg;
   typedef struct packed {
      logic [5:0] pend_vec;
      logic ret_base;
      logic [5:0] act_vec;
   } exst_status_t;
   typedef enum logic [1:0] {
      EXST_IDLE,
      EXST_ACCESS
   } exst_apb_st_t;
endpackage

// [design/exst_status.sv]
// Exception state status fields: pending vector, return-to-base flag, active vector.
// Assumes the core supplies pending/enable/active/priority vectors per exception number
// and its current handler number on the same clock; software reads over APB.
//
// How it works
// - Bits 17:12 show highest-priority enabled pending exception number.
// - Pending field reads zero when nothing is pending.
// - Pendable service call is 0x0E, system tick 0x0F, interrupt n 0x10+n.
// - Interrupts up to 43 (0x3B); codes 0x3C-0x3F never reported.
// - Bit 11 low when preempted active exceptions still wait.
// - Bit 11 high when none active or only the current one active.
// - Bit 11 considers pendable service call, system tick and interrupts only, not NMI, faults or SVCall.
// - Bit 11 only meaningful while the current handler number is nonzero.
// - Bits 5:0 show the active exception number in the same encoding.
// - Active field reads zero in Thread mode.
// - Active field always equals the previous clock's handler number in the program status.
//
// The register addresses and register access over APB are this design's own decisions.
`include "exst_defines.svh"
module exst_status
   import exst_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [`EXST_NUM_SLOTS-1:0] i_pending,
   input wire logic [`EXST_NUM_SLOTS-1:0] i_enabled,
   input wire logic [`EXST_NUM_SLOTS-1:0] i_active,
   input wire logic [`EXST_NUM_SLOTS*`EXST_PRIO_W-1:0] i_prio,
   input wire logic [5:0] i_current_handler_number,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic [5:0] o_pending_vector_number,
   output logic o_return_to_base_flag,
   output logic [5:0] o_active_vector_number
);
   exst_status_t stat_d;
   exst_status_t stat_q;
   logic [`EXST_NUM_SLOTS-1:0] valid_slot;
   logic [`EXST_NUM_SLOTS-1:0] cand;
   logic [`EXST_NUM_SLOTS-1:0] other_irq_act;

   // Only implemented exception numbers take part; reserved codes are masked.
   genvar g;
   for (g = 0; g < `EXST_NUM_SLOTS; g++) begin : g_slot
      localparam logic [5:0] CODE = 6'(g);
      // Codes 1, 7 to 10, 12, 13 and everything above the last interrupt are reserved.
      assign valid_slot[g] = ((CODE >= `EXST_VEC_NMI) && (CODE <= `EXST_VEC_FAULT_LAST))
         || (CODE == `EXST_VEC_SVCALL)
         || ((CODE >= `EXST_VEC_PENDSVC) && (CODE <= `EXST_VEC_IRQMAX));
      assign cand[g] = valid_slot[g] && i_pending[g] && i_enabled[g];
      assign other_irq_act[g] = (CODE >= `EXST_VEC_PENDSVC) && (CODE <= `EXST_VEC_IRQMAX) && i_active[g]
         && (CODE != i_current_handler_number);
      a_code_barred: assert property (@(posedge i_clk) disable iff (!i_rst_n)
         ((CODE != `EXST_VEC_NONE) && !valid_slot[g]) |-> o_pending_vector_number != CODE)
         else $error("reserved exception code reported");
   end

   // Lowest priority value wins; ties go to the lower exception number.
   always_comb begin
      logic [`EXST_PRIO_W:0] best;
      logic [`EXST_PRIO_W:0] p;
      best = `EXST_PRIO_NONE;
      p = `EXST_PRIO_NONE;
      stat_d.pend_vec = `EXST_VEC_NONE;
      for (int k = 0; k < `EXST_NUM_SLOTS; k++) begin
         p = {1'b0, i_prio[k*`EXST_PRIO_W +: `EXST_PRIO_W]};
         if (cand[k] && (p < best)) begin
            best = p;
            stat_d.pend_vec = 6'(k);
         end
      end
      stat_d.ret_base = ~|other_irq_act;
      stat_d.act_vec = i_current_handler_number;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stat_q <= '0;
      end else begin
         stat_q <= stat_d;
      end
   end

   assign o_pending_vector_number = stat_q.pend_vec;
   assign o_return_to_base_flag = stat_q.ret_base;
   assign o_active_vector_number = stat_q.act_vec;

   // APB slave: one wait state, read data registered, writes discarded.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= `EXST_ZERO32;
      end else begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= `EXST_ZERO32;
         if (i_psel && i_penable && !o_pready) begin
            o_pready <= 1'b1;
            if (i_paddr != `EXST_ADDR_STATUS) begin
               o_pslverr <= 1'b1;
            end else if (!i_pwrite) begin
               o_prdata[`EXST_PEND_MSB:`EXST_PEND_LSB] <= stat_q.pend_vec;
               o_prdata[`EXST_RETURN_TO_BASE_FLAG_BIT] <= stat_q.ret_base;
               o_prdata[`EXST_ACT_MSB:0] <= stat_q.act_vec;
            end
            // A write to the status word stores nothing.
         end
      end
   end

   a_act_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      1'b1 |=> o_active_vector_number == $past(i_current_handler_number))
      else $error("active field does not track handler number");
   a_thread_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_current_handler_number == 6'h00 |=> o_active_vector_number == 6'h00)
      else $error("active field nonzero in thread mode");
   a_pend_none: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_pending & i_enabled) == '0 |=> o_pending_vector_number == 6'h00)
      else $error("pending field nonzero with nothing pending");
   a_pend_reserved: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_pending_vector_number <= 6'h3B)
      else $error("reserved pending code reported");
   a_pend_is_pending: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_pending_vector_number != 6'h00 |-> |($past(i_pending) & $past(i_enabled)
         & (64'h1 << o_pending_vector_number)))
      else $error("pending field names an exception not pending");
   a_ret_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_active[16] && i_current_handler_number == 6'h11) |=> !o_return_to_base_flag)
      else $error("return flag high with preempted interrupt");
   a_ret_high: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_active == '0) |=> o_return_to_base_flag)
      else $error("return flag low with nothing active");
   a_ret_faults: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      ((i_active & 64'hFFFF_FFFF_FFFF_C000) == '0) |=> o_return_to_base_flag)
      else $error("faults affect return flag");
   a_read_once: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_pready |=> !o_pready)
      else $error("ready held for two cycles");
   a_read_data: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_psel && i_penable && !o_pready && !i_pwrite && i_paddr == 12'hD04)
      |=> o_prdata[5:0] == $past(o_active_vector_number) && o_prdata[10:6] == 5'h00)
      else $error("read data does not show active field");
   a_ret_alone: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_current_handler_number != `EXST_VEC_NONE && i_active == (64'h1 << i_current_handler_number))
      |=> o_return_to_base_flag)
      else $error("return flag low with only the current handler active");
   a_take_ready: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_psel && i_penable && !o_pready) |=> o_pready)
      else $error("access not answered after one wait state");
   a_err_map: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_psel && i_penable && !o_pready && i_paddr != `EXST_ADDR_STATUS) |=> o_pslverr)
      else $error("unmapped access without error");
   a_write_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_psel && i_penable && !o_pready && i_pwrite) |=> o_prdata == `EXST_ZERO32)
      else $error("write returned data");
   a_rsvd_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_pready |-> o_prdata[`EXST_RETURN_TO_BASE_FLAG_BIT-1:`EXST_ACT_MSB+1] == 5'h00)
      else $error("reserved read bits nonzero");
endmodule

// [tb/exst_core_model.sv]
// Behavioural core: per-number pending, enable, active and priority, plus the current handler.
// Assumes the bench calls its tasks just after a rising edge; state changes by non-blocking update.
module exst_core_model (
   input wire logic i_clk,
   output logic [63:0] o_pending,
   output logic [63:0] o_enabled,
   output logic [63:0] o_active,
   output logic [191:0] o_prio,
   output logic [5:0] o_handler
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {o_pending, o_enabled, o_active, o_prio, o_handler} = '0;
   end
   task automatic pend(input int n, input logic [2:0] p);
      @(posedge i_clk);
      o_pending[n] <= 1'b1;
      o_enabled[n] <= 1'b1;
      o_prio[3*n +: 3] <= p;
   endtask
   // Entering a handler leaves the preempted one active.
   task automatic enter(input int n);
      @(posedge i_clk);
      o_active[n] <= 1'b1;
      o_handler <= n[5:0];
   endtask
endmodule

// [tb/test_exst_status.sv]
// Bench for the exception status block: reads the status word over APB while the core model moves.
// Assumes the core model file and the package are compiled first.
module test_exst_status;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, ret, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [5:0] pend_v, act_v, hnd;
   logic [63:0] pnd, ena, act;
   logic [191:0] pri;
   int miscompares = 0;
   int n_tests = 0;
   always #25 clk = ~clk;
   exst_core_model core (.i_clk(clk), .o_pending(pnd), .o_enabled(ena), .o_active(act), .o_prio(pri),
      .o_handler(hnd));
   exst_status i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_pending(pnd), .i_enabled(ena), .i_active(act),
      .i_prio(pri), .i_current_handler_number(hnd), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .o_pending_vector_number(pend_v), .o_return_to_base_flag(ret), .o_active_vector_number(act_v));
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      n_tests++;
      if (g !== x) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         miscompares++;
         conclude();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input string nm, input logic [31:0] x);
      apb(1'b0, 12'hD04, 32'h0000_0000);
      chk(nm, x, q);
   endtask
   initial begin
      {clk, rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd("idle", 32'h0000_0800);
      core.pend(59, 3'h5);
      core.pend(14, 3'h6);
      rd("irq43", 32'h0003_B800);
      core.pend(15, 3'h1);
      rd("tick", 32'h0000_F800);
      core.enter(3);
      core.enter(16);
      rd("fault_left_out", 32'h0000_F810);
      core.enter(17);
      rd("preempted", 32'h0000_F011);
      chk("act_port", 32'h0000_0011, {26'h0, act_v});
      chk("pend_port", 32'h0000_000F, {26'h0, pend_v});
      chk("ret_port", 32'h0000_0000, {31'h0, ret});
      chk("irq_index", 32'h0000_0001, {26'h0, q[5:0] - 6'h10});
      apb(1'b1, 12'hD04, q);
      chk("rmw_err", 32'h0000_0000, {31'h0, e});
      apb(1'b1, 12'hD04, 32'hFFFF_FFFF);
      chk("write_err", 32'h0000_0000, {31'h0, e});
      rd("after_write", 32'h0000_F011);
      apb(1'b0, 12'hD08, 32'h0000_0000);
      chk("unmapped_err", 32'h0000_0001, {31'h0, e});
      conclude();
   end
endmodule
